/* File: rtl/smie_exec.sv */
`timescale 1ns/1ns
module smie_exec
  import smie_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk_sys_in,
  input  wire logic                    resetn_in,
  // Instruction issue
  input  wire logic                    issue_valid_in,
  input  wire smie_instr_t             instr_in,
  // Direct pointer load
  input  wire logic                    ptr_load_in,
  input  wire logic                    ptr_load_sel_in,
  input  wire logic [SMIE_PTR_W-1:0]   ptr_load_val_in,
  // Indirect data read
  input  wire logic [SMIE_DATA_W-1:0]  mem_rdata_in,
  output logic                         mem_rd_out,
  output logic      [SMIE_PTR_W-1:0]   mem_addr_out,
  // File register write back
  output smie_fwrite_t                 fwrite_out,
  // Core state
  output logic      [SMIE_DATA_W-1:0]  acc_out,
  output logic                         carry_out,
  output logic                         zero_out,
  output logic      [SMIE_PTR_W-1:0]   ptr0_out,
  output logic      [SMIE_PTR_W-1:0]   ptr1_out,
  output logic                         busy_out,
  output logic                         done_out
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  // One extra state covers the single-cycle indirect read
  typedef enum logic {
    SMIE_ST_IDLE,
    SMIE_ST_LOAD_WAIT
  } smie_state_t;

  smie_state_t            state_d;
  smie_state_t            state_q;
  logic [SMIE_DATA_W-1:0] acc_d;
  logic [SMIE_DATA_W-1:0] acc_q;
  logic                   carry_d;
  logic                   carry_q;
  logic                   zero_d;
  logic                   zero_q;
  smie_fwrite_t           fwrite_d;
  smie_fwrite_t           fwrite_q;
  logic                   mem_rd_d;
  logic                   mem_rd_q;
  logic [SMIE_PTR_W-1:0]  mem_addr_d;
  logic [SMIE_PTR_W-1:0]  mem_addr_q;
  logic                   done_d;
  logic                   done_q;
  logic                   busy_d;
  logic                   busy_q;

  // ----------------------------------------
  // Pointer pair
  // ----------------------------------------
  logic [SMIE_PTR_W-1:0] ptr_val [SMIE_NPTR];
  logic [SMIE_NPTR-1:0]  step_en;
  logic                  step_down;
  logic [SMIE_PTR_W-1:0] sel_ptr;
  logic [SMIE_PTR_W-1:0] off_ext;
  logic [SMIE_PTR_W-1:0] eff_addr;
  logic [SMIE_DATA_W-1:0] shift_res;
  logic                  take;

  // Busy state refuses a new issue; nothing is queued
  assign take      = issue_valid_in && (state_q == SMIE_ST_IDLE);
  assign sel_ptr   = ptr_val[instr_in.ptr_sel]; // RL11
  assign off_ext   = {{(SMIE_PTR_W-SMIE_OFF_W){instr_in.offset[SMIE_OFF_W-1]}}, instr_in.offset};
  assign step_down = instr_in.upd_code[0];
  // Old bit 0 leaves through carry, zero enters at the top
  assign shift_res = {1'b0, instr_in.fdata[SMIE_DATA_W-1:1]}; // RL1

  // ----------------------------------------
  // Effective address
  // ----------------------------------------
  // Pre modes address the stepped value, post modes the old one
  always_comb begin
    unique case (instr_in.upd_code)
      SMIE_UPD_PREINC:  eff_addr = sel_ptr + SMIE_PTR_ONE; // RL6 RL9
      SMIE_UPD_PREDEC:  eff_addr = sel_ptr - SMIE_PTR_ONE; // RL6 RL9
      SMIE_UPD_POSTINC: eff_addr = sel_ptr; // RL6
      SMIE_UPD_POSTDEC: eff_addr = sel_ptr; // RL6
    endcase
    // Offset form wins over whatever update code rides along
    if (instr_in.rel_form) begin
      eff_addr = sel_ptr + off_ext; // RL7 RL9
    end
  end

  // ----------------------------------------
  // Pointer stepping
  // ----------------------------------------
  // Only the chosen pointer steps; offset form never steps
  always_comb begin
    step_en = '0;
    if (take && instr_in.op == SMIE_OP_INDIRECT_LOAD && !instr_in.rel_form) begin
      step_en[instr_in.ptr_sel] = 1'b1; // RL7 RL8 RL11
    end
  end

  // A direct load in the same cycle beats the step inside the unit
  for (genvar gi = 0; gi < SMIE_NPTR; gi++) begin : g_ptr
    smie_ptr_unit u_ptr (
      .clk_sys_in   (clk_sys_in),
      .resetn_in    (resetn_in),
      .load_in      (ptr_load_in && (ptr_load_sel_in == 1'(gi))),
      .load_val_in  (ptr_load_val_in),
      .step_in      (step_en[gi]),
      .step_down_in (step_down),
      .ptr_out      (ptr_val[gi])
    );
  end

  // ----------------------------------------
  // Execution
  // ----------------------------------------
  always_comb begin
    state_d    = state_q;
    acc_d      = acc_q;
    carry_d    = carry_q;
    zero_d     = zero_q;
    // Address and data read as zero between writes
    fwrite_d   = '0;
    mem_rd_d   = 1'b0;
    mem_addr_d = mem_addr_q;
    done_d     = 1'b0;
    busy_d     = 1'b0;
    unique case (state_q)
      SMIE_ST_IDLE: begin
        if (take) begin
          unique case (instr_in.op)
            SMIE_OP_SHIFT_RIGHT: begin
              carry_d = instr_in.fdata[0]; // RL1
              zero_d  = (shift_res == SMIE_DATA_RST); // RL1
              done_d  = 1'b1;
              if (instr_in.dest == SMIE_DEST_ACC) begin
                acc_d = shift_res; // RL2
              end else begin
                fwrite_d = '{we: 1'b1, addr: instr_in.faddr, data: shift_res}; // RL2
              end
            end
            SMIE_OP_FILE_COPY: begin
              // Carry is left alone by a copy
              zero_d = (instr_in.fdata == SMIE_DATA_RST); // RL4
              done_d = 1'b1; // RL4
              if (instr_in.dest == SMIE_DEST_ACC) begin
                acc_d = instr_in.fdata; // RL3
              end else begin
                fwrite_d = '{we: 1'b1, addr: instr_in.faddr, data: instr_in.fdata}; // RL3
              end
            end
            SMIE_OP_INDIRECT_LOAD: begin
              // Window is not storage: read goes out at the pointer address
              mem_rd_d   = 1'b1; // RL5
              mem_addr_d = eff_addr; // RL5
              busy_d     = 1'b1;
              state_d    = SMIE_ST_LOAD_WAIT;
            end
            SMIE_OP_NONE: begin
              // Taken, but touches no state
              done_d = 1'b0;
            end
          endcase
        end
      end
      SMIE_ST_LOAD_WAIT: begin
        // Read data stands in the same cycle as the mem_rd_out request
        acc_d   = mem_rdata_in; // RL5
        zero_d  = (mem_rdata_in == SMIE_DATA_RST); // RL10
        done_d  = 1'b1;
        state_d = SMIE_ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q    <= SMIE_ST_IDLE;
      acc_q      <= SMIE_DATA_RST;
      carry_q    <= 1'b0;
      zero_q     <= 1'b0;
      fwrite_q   <= '0;
      mem_rd_q   <= 1'b0;
      mem_addr_q <= SMIE_PTR_RST;
      done_q     <= 1'b0;
      busy_q     <= 1'b0;
    end else begin
      state_q    <= state_d;
      acc_q      <= acc_d;
      carry_q    <= carry_d;
      zero_q     <= zero_d;
      fwrite_q   <= fwrite_d;
      mem_rd_q   <= mem_rd_d;
      mem_addr_q <= mem_addr_d;
      done_q     <= done_d;
      busy_q     <= busy_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign acc_out      = acc_q;
  assign carry_out    = carry_q;
  assign zero_out     = zero_q;
  assign fwrite_out   = fwrite_q;
  assign mem_rd_out   = mem_rd_q;
  assign mem_addr_out = mem_addr_q;
  assign done_out     = done_q;
  assign busy_out     = busy_q;
  // Pointers come straight from the unit flops
  assign ptr0_out     = ptr_val[0];
  assign ptr1_out     = ptr_val[1];

endmodule // smie_exec

/* File: rtl/smie_pkg.sv */
// Operation
// RL1: Right shift inserts zero at top, old bit 0 to carry, zero flag from result.
// RL2: Shift result goes to accumulator if dest is 0, else back to file register.
// RL3: File copy goes to accumulator if dest is 0, else back to same register.
// RL4: File copy sets zero flag from value; one word, one instruction cycle.
// RL5: Indirect load reads register at selected pointer address into accumulator.
// RL6: Update code 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec.
// RL7: Offset form uses pointer plus signed -32..31 offset; pointer stays unchanged.
// RL8: Afterwards pointer is one higher for increments, one lower for decrements.
// RL9: Pointer is 16 bits and wraps modulo 65536 without fault.
// RL10: Indirect load sets zero flag from loaded value.
// RL11: Operand selects one of two pointers; only the selected one is updated.
package smie_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int unsigned SMIE_DATA_W  = 8;
  localparam int unsigned SMIE_FADDR_W = 7;
  localparam int unsigned SMIE_PTR_W   = 16;
  localparam int unsigned SMIE_OFF_W   = 6;
  localparam int unsigned SMIE_NPTR    = 2;

  // ----------------------------------------
  // Codes and reset values
  // ----------------------------------------
  localparam logic       SMIE_DEST_ACC   = 1'b0;
  localparam logic [1:0] SMIE_UPD_PREINC = 2'b00;
  localparam logic [1:0] SMIE_UPD_PREDEC = 2'b01;
  localparam logic [1:0] SMIE_UPD_POSTINC = 2'b10;
  localparam logic [1:0] SMIE_UPD_POSTDEC = 2'b11;
  localparam logic [SMIE_PTR_W-1:0]  SMIE_PTR_RST  = 16'h0000;
  localparam logic [SMIE_PTR_W-1:0]  SMIE_PTR_ONE  = 16'h0001;
  localparam logic [SMIE_DATA_W-1:0] SMIE_DATA_RST = 8'h00;
  localparam logic [SMIE_FADDR_W-1:0] SMIE_FADDR_RST = 7'h00;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    SMIE_OP_NONE,
    SMIE_OP_SHIFT_RIGHT,
    SMIE_OP_FILE_COPY,
    SMIE_OP_INDIRECT_LOAD
  } smie_op_t;

  typedef struct packed {
    smie_op_t                op;
    logic                    dest;
    logic [SMIE_FADDR_W-1:0] faddr;
    logic [SMIE_DATA_W-1:0]  fdata;
    logic                    ptr_sel;
    logic                    rel_form;
    logic [1:0]              upd_code;
    logic [SMIE_OFF_W-1:0]   offset;
  } smie_instr_t;

  typedef struct packed {
    logic                    we;
    logic [SMIE_FADDR_W-1:0] addr;
    logic [SMIE_DATA_W-1:0]  data;
  } smie_fwrite_t;

endpackage

/* File: rtl/smie_ptr_unit.sv */
`timescale 1ns/1ns
module smie_ptr_unit
  import smie_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk_sys_in,
  input  wire logic                  resetn_in,
  // Direct load from the core
  input  wire logic                  load_in,
  input  wire logic [SMIE_PTR_W-1:0] load_val_in,
  // Step after an indirect load
  input  wire logic                  step_in,
  input  wire logic                  step_down_in,
  // Pointer value
  output logic      [SMIE_PTR_W-1:0] ptr_out
);

  logic [SMIE_PTR_W-1:0] ptr_d;
  logic [SMIE_PTR_W-1:0] ptr_q;

  always_comb begin
    ptr_d = ptr_q;
    if (load_in) begin
      ptr_d = load_val_in;
    end else if (step_in) begin
      // Plain 16-bit sum, so 0000h-1 and FFFFh+1 wrap
      ptr_d = step_down_in ? ptr_q - SMIE_PTR_ONE : ptr_q + SMIE_PTR_ONE; // RL8 RL9
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ptr_q <= SMIE_PTR_RST;
    end else begin
      ptr_q <= ptr_d;
    end
  end

  assign ptr_out = ptr_q;

endmodule // smie_ptr_unit

/* File: testbench/smie_exec_sva.sv */
`timescale 1ns/1ns
module smie_exec_sva
  import smie_pkg::*;
(
  // Watched ports
  input wire logic         clk_sys_in,
  input wire logic         resetn_in,
  input wire logic         issue_valid_in,
  input wire smie_instr_t  instr_in,
  input wire logic         ptr_load_in,
  input wire logic [7:0]   mem_rdata_in,
  input wire logic         mem_rd_out,
  input wire logic [15:0]  mem_addr_out,
  input wire smie_fwrite_t fwrite_out,
  input wire logic [7:0]   acc_out,
  input wire logic         carry_out,
  input wire logic         zero_out,
  input wire logic [15:0]  ptr0_out,
  input wire logic         busy_out,
  input wire logic         done_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);
  // Pointer loads excluded: they override a step
  logic        go;
  smie_instr_t i;
  assign go = issue_valid_in && !busy_out && !ptr_load_in;
  assign i  = instr_in;
  logic        ind0;
  assign ind0 = go && i.op == SMIE_OP_INDIRECT_LOAD && !i.ptr_sel;
  property p_shr;
    go && i.op == SMIE_OP_SHIFT_RIGHT |=> done_out && carry_out == $past(i.fdata[0])
      && zero_out == ($past(i.fdata[7:1]) == 7'h00);
  endproperty
  a_shr: assert property (p_shr) else $error("shift flags wrong");
  property p_sacc;
    go && i.op == SMIE_OP_SHIFT_RIGHT && !i.dest |=> acc_out == {1'b0, $past(i.fdata[7:1])};
  endproperty
  a_sacc: assert property (p_sacc) else $error("shift to acc wrong");
  property p_swr;
    go && i.op == SMIE_OP_SHIFT_RIGHT && i.dest
      |=> fwrite_out == {1'b1, $past(i.faddr), 1'b0, $past(i.fdata[7:1])};
  endproperty
  a_swr: assert property (p_swr) else $error("shift write back wrong");
  property p_cacc;
    go && i.op == SMIE_OP_FILE_COPY && !i.dest |=> acc_out == $past(i.fdata)
      && zero_out == ($past(i.fdata) == 8'h00) && $stable(carry_out);
  endproperty
  a_cacc: assert property (p_cacc) else $error("copy to acc wrong");
  property p_cwr;
    go && i.op == SMIE_OP_FILE_COPY && i.dest
      |=> done_out && fwrite_out == {1'b1, $past(i.faddr), $past(i.fdata)};
  endproperty
  a_cwr: assert property (p_cwr) else $error("copy write back wrong");
  property p_ind;
    go && i.op == SMIE_OP_INDIRECT_LOAD |=> mem_rd_out && busy_out && !done_out
      ##1 done_out && acc_out == $past(mem_rdata_in) && zero_out == (acc_out == 8'h00);
  endproperty
  a_ind: assert property (p_ind) else $error("indirect load wrong");
  property p_rel;
    ind0 && i.rel_form |=> $stable(ptr0_out)
      && mem_addr_out == $past(ptr0_out) + {{10{$past(i.offset[5])}}, $past(i.offset)};
  endproperty
  a_rel: assert property (p_rel) else $error("offset address wrong");
  property p_ea;
    ind0 && !i.rel_form |=> mem_addr_out == $past(ptr0_out) + ($past(i.upd_code[1]) ?
      16'h0000 : ($past(i.upd_code[0]) ? 16'hffff : 16'h0001));
  endproperty
  a_ea: assert property (p_ea) else $error("effective address wrong");
  property p_step;
    ind0 && !i.rel_form
      |=> ptr0_out == $past(ptr0_out) + ($past(i.upd_code[0]) ? 16'hffff : 16'h0001);
  endproperty
  a_step: assert property (p_step) else $error("pointer step wrong");
  property p_keep;
    go && i.op == SMIE_OP_INDIRECT_LOAD && i.ptr_sel |=> $stable(ptr0_out);
  endproperty
  a_keep: assert property (p_keep) else $error("unselected pointer moved");
  c_swr: cover property (go && i.op == SMIE_OP_SHIFT_RIGHT && i.dest);
  c_ind: cover property (ind0 && !i.rel_form);
  c_rel: cover property (go && i.op == SMIE_OP_INDIRECT_LOAD && i.rel_form);
endmodule // smie_exec_sva

/* File: testbench/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  import smie_pkg::*;
  logic         clk_sys_in;
  logic         resetn_in;
  logic         issue_valid_in;
  smie_instr_t  instr_in;
  logic         ptr_load_in;
  logic         ptr_load_sel_in;
  logic [15:0]  ptr_load_val_in;
  logic [7:0]   mem_rdata_in;
  logic         mem_rd_out;
  logic [15:0]  mem_addr_out;
  smie_fwrite_t fwrite_out;
  logic [7:0]   acc_out;
  logic         carry_out;
  logic         zero_out;
  logic [15:0]  ptr0_out;
  logic [15:0]  ptr1_out;
  logic         busy_out;
  logic         done_out;
  int           fail_count = 0;
  int           check_count = 0;
  smie_exec dut_u (.*);
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  // Watchdog: the whole run needs well under 200 cycles
  initial begin
    repeat (2000) @(posedge clk_sys_in);
    fail_count++;
    stop_test();
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic issue(input smie_instr_t i, input logic [7:0] rd);
    @(posedge clk_sys_in);
    instr_in       <= i;
    issue_valid_in <= 1'b1;
    @(posedge clk_sys_in);
    issue_valid_in <= 1'b0;
    mem_rdata_in   <= rd;
    #1;
  endtask
  task automatic sc(input smie_op_t op, input logic d, input logic [7:0] f);
    issue({op, d, 7'h12, f, 1'b0, 1'b0, 2'b00, 6'h00}, 8'h00);
  endtask
  task automatic pload(input logic s, input logic [15:0] v);
    @(posedge clk_sys_in);
    ptr_load_in     <= 1'b1;
    ptr_load_sel_in <= s;
    ptr_load_val_in <= v;
    @(posedge clk_sys_in);
    ptr_load_in     <= 1'b0;
  endtask
  task automatic ind(input logic s, input logic r, input logic [1:0] u, input logic [5:0] o,
                     input logic [7:0] rd, input logic [15:0] ea, input logic [15:0] pa);
    issue({SMIE_OP_INDIRECT_LOAD, 1'b0, 7'h00, 8'h00, s, r, u, o}, rd);
    chk({mem_rd_out, busy_out}, 2'b11);
    chk(mem_addr_out, ea);
    chk(s ? ptr1_out : ptr0_out, pa);
    @(posedge clk_sys_in);
    // Read data no longer held: show its inverse
    mem_rdata_in <= ~rd;
    #1;
    chk({done_out, zero_out, acc_out}, {1'b1, rd == 8'h00, rd});
  endtask
  initial begin
    resetn_in       = 1'b0;
    issue_valid_in  = 1'b0;
    instr_in        = '0;
    ptr_load_in     = 1'b0;
    ptr_load_sel_in = 1'b0;
    ptr_load_val_in = 16'h0000;
    mem_rdata_in    = 8'h00;
    repeat (12) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    #1;
    chk({acc_out, carry_out, zero_out, ptr0_out}, 32'h0000_0000);
    sc(SMIE_OP_SHIFT_RIGHT, 1'b1, 8'ha6);
    chk({fwrite_out, acc_out, carry_out, zero_out}, {1'b1, 7'h12, 8'h53, 8'h00, 2'b00});
    sc(SMIE_OP_SHIFT_RIGHT, 1'b0, 8'h01);
    chk({acc_out, carry_out, zero_out, fwrite_out.we}, {8'h00, 3'b110});
    sc(SMIE_OP_FILE_COPY, 1'b1, 8'h00);
    chk({fwrite_out, carry_out, zero_out, done_out}, {1'b1, 7'h12, 8'h00, 3'b111});
    sc(SMIE_OP_FILE_COPY, 1'b0, 8'h5a);
    chk({acc_out, carry_out, zero_out, fwrite_out.we}, {8'h5a, 3'b100});
    sc(SMIE_OP_NONE, 1'b1, 8'hff);
    chk({acc_out, carry_out, zero_out, fwrite_out.we, done_out}, {8'h5a, 4'b1000});
    pload(1'b0, 16'hffff);
    pload(1'b1, 16'h1234);
    ind(1'b0, 1'b0, 2'b00, 6'h00, 8'h3c, 16'h0000, 16'h0000);
    ind(1'b0, 1'b0, 2'b01, 6'h00, 8'h00, 16'hffff, 16'hffff);
    ind(1'b0, 1'b0, 2'b10, 6'h00, 8'h81, 16'hffff, 16'h0000);
    ind(1'b0, 1'b0, 2'b11, 6'h00, 8'h7e, 16'h0000, 16'hffff);
    ind(1'b0, 1'b1, 2'b01, 6'h3f, 8'h01, 16'hfffe, 16'hffff);
    chk(ptr1_out, 16'h1234);
    ind(1'b1, 1'b1, 2'b00, 6'h20, 8'h55, 16'h1214, 16'h1234);
    ind(1'b1, 1'b1, 2'b11, 6'h1f, 8'h00, 16'h1253, 16'h1234);
    chk(ptr0_out, 16'hffff);
    // Shift offered while the read is outstanding is refused
    @(posedge clk_sys_in);
    instr_in       <= {SMIE_OP_INDIRECT_LOAD, 1'b0, 7'h00, 8'h00, 1'b1, 1'b1, 2'b00, 6'h00};
    issue_valid_in <= 1'b1;
    @(posedge clk_sys_in);
    instr_in       <= {SMIE_OP_SHIFT_RIGHT, 1'b1, 7'h12, 8'h02, 1'b0, 1'b0, 2'b00, 6'h00};
    mem_rdata_in   <= 8'h99;
    @(posedge clk_sys_in);
    issue_valid_in <= 1'b0;
    mem_rdata_in   <= 8'h66;
    #1;
    chk({done_out, acc_out, carry_out, fwrite_out.we}, {1'b1, 8'h99, 2'b10});
    @(posedge clk_sys_in);
    #1;
    chk({done_out, carry_out, fwrite_out.we}, 3'b010);
    stop_test();
  end
endmodule // tb_top
bind smie_exec smie_exec_sva chk_u (.*);
